// ==== logic/sllt_regs.sv ====
// register bank and limiters for the servo controller cascade
// assumes an axi4-lite master on ref_clk and cascade signals on the same clock
// What this block does
// - circular limit of voltage vector, absolute setting
// - one current limit bounds torque and flux
// - velocity input bounded by absolute speed limit
// - lower barrier on position controller input
// - upper barrier on position controller input
// - motion mode field selects operating mode
// - seven bit outer loop downsampling factor
// - bit 31 selects PI structure
// - torque mode uses flux and torque setpoints
// - flux and torque feed-forward offsets added
// - velocity mode uses speed setpoint
// - speed feed-forward in velocity and position
// - position mode uses position setpoint
// - report measured flux and torque currents
// - report filtered measured speed
// - report position from selected angle
// - accumulate angle differences, multi-turn position
// - measured position write also sets setpoint
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module sllt_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // measurements from the cascade
    input wire sllt_pkg::sllt_dq_s measured_currents_in,
    input wire logic signed [31:0] measured_speed_in,
    input wire logic signed [15:0] selected_angle,
    input wire logic selected_angle_valid,
    // voltage vector ahead of the inverse park stage
    input wire logic signed [15:0] volt_d_in,
    input wire logic signed [15:0] volt_q_in,
    output logic signed [15:0] volt_d_out,
    output logic signed [15:0] volt_q_out,
    // outer loop output feeding the velocity controller in position mode
    input wire logic signed [31:0] position_loop_out,
    // controller setpoints and configuration
    output sllt_pkg::sllt_dq_s current_loop_target,
    output logic signed [31:0] speed_loop_target,
    output logic signed [31:0] position_loop_target,
    output sllt_pkg::sllt_cfg_s loop_config,
    output logic signed [31:0] measured_position
);

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic signed [31:0] clamp32(input logic signed [32:0] v,
                                                   input logic signed [32:0] lo,
                                                   input logic signed [32:0] hi);
        logic signed [32:0] t;
        t = v;
        if (v < lo) begin
            t = lo;
        end else if (v > hi) begin
            t = hi;
        end
        return t[31:0];
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic addr_ok(input logic [31:0] a);
        logic [7:0] idx;
        idx = a[sllt_pkg::ADDR_IDX_MSB:sllt_pkg::ADDR_IDX_LSB];
        return (a[31:sllt_pkg::ADDR_IDX_MSB+1] == '0) && (a[1:0] == 2'h0) &&
               (idx == sllt_pkg::IDX_VOLT_LIM ||
                (idx >= sllt_pkg::IDX_CUR_LIM && idx <= sllt_pkg::IDX_MEAS_POS &&
                 idx != 8'h5f));
    endfunction

    // ************************************************
    // registers
    // ************************************************
    logic [31:0] volt_lim_r, cur_lim_r, spd_lim_r, pos_low_r, pos_high_r, mode_r;
    logic [31:0] cur_set_r, cur_ff_r, spd_set_r, spd_ff_r, pos_set_r;
    logic signed [31:0] meas_pos_r;
    logic signed [15:0] prev_angle_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [31:0] awaddr_r, wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic do_write;
    logic [7:0] widx;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign widx = awaddr_r[sllt_pkg::ADDR_IDX_MSB:sllt_pkg::ADDR_IDX_LSB];

    // address and data are caught separately, in either order
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_r <= 1'b0;
            awaddr_r <= sllt_pkg::REG_RST;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            w_held_r <= 1'b0;
            wdata_r <= sllt_pkg::REG_RST;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bvalid_r <= 1'b0;
            bresp_r <= sllt_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= addr_ok(awaddr_r) ? sllt_pkg::RESP_OKAY : sllt_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read-only measurement registers ignore writes but still answer okay
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            volt_lim_r <= sllt_pkg::REG_RST;
            cur_lim_r <= sllt_pkg::REG_RST;
            spd_lim_r <= sllt_pkg::REG_RST;
            pos_low_r <= sllt_pkg::REG_RST;
            pos_high_r <= sllt_pkg::REG_RST;
            mode_r <= sllt_pkg::REG_RST;
            cur_set_r <= sllt_pkg::REG_RST;
            cur_ff_r <= sllt_pkg::REG_RST;
            spd_set_r <= sllt_pkg::REG_RST;
            spd_ff_r <= sllt_pkg::REG_RST;
            pos_set_r <= sllt_pkg::REG_RST;
        end else if (do_write && addr_ok(awaddr_r)) begin
            case (widx)
                sllt_pkg::IDX_VOLT_LIM: volt_lim_r <= strb_merge(volt_lim_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_CUR_LIM: cur_lim_r <= strb_merge(cur_lim_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_SPD_LIM: spd_lim_r <= strb_merge(spd_lim_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_POS_LOW: pos_low_r <= strb_merge(pos_low_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_POS_HIGH: pos_high_r <= strb_merge(pos_high_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_MODE: mode_r <= strb_merge(mode_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_CUR_SET: cur_set_r <= strb_merge(cur_set_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_CUR_FF: cur_ff_r <= strb_merge(cur_ff_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_SPD_SET: spd_set_r <= strb_merge(spd_set_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_SPD_FF: spd_ff_r <= strb_merge(spd_ff_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_POS_SET: pos_set_r <= strb_merge(pos_set_r, wdata_r, wstrb_r);
                sllt_pkg::IDX_MEAS_POS: pos_set_r <= strb_merge(meas_pos_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // ************************************************
    // multi-turn position
    // ************************************************
    // accumulate angle differences
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meas_pos_r <= sllt_pkg::REG_RST;
            prev_angle_r <= 16'sh0000;
        end else begin
            if (selected_angle_valid) begin
                prev_angle_r <= selected_angle;
            end
            // software write wins over an angle step in the same cycle
            if (do_write && addr_ok(awaddr_r) && widx == sllt_pkg::IDX_MEAS_POS) begin
                meas_pos_r <= strb_merge(meas_pos_r, wdata_r, wstrb_r);
            end else if (selected_angle_valid) begin
                meas_pos_r <= meas_pos_r + {{16{1'b0}} | 32'(signed'(16'(selected_angle -
                              prev_angle_r)))};
            end
        end
    end
    assign measured_position = meas_pos_r;

    // ************************************************
    // register read
    // ************************************************
    logic [31:0] rd_mux;
    logic [7:0] ridx;
    assign ridx = s_axi_araddr[sllt_pkg::ADDR_IDX_MSB:sllt_pkg::ADDR_IDX_LSB];

    always_comb begin
        case (ridx)
            sllt_pkg::IDX_VOLT_LIM: rd_mux = volt_lim_r;
            sllt_pkg::IDX_CUR_LIM: rd_mux = cur_lim_r;
            sllt_pkg::IDX_SPD_LIM: rd_mux = spd_lim_r;
            sllt_pkg::IDX_POS_LOW: rd_mux = pos_low_r;
            sllt_pkg::IDX_POS_HIGH: rd_mux = pos_high_r;
            sllt_pkg::IDX_MODE: rd_mux = mode_r;
            sllt_pkg::IDX_CUR_SET: rd_mux = cur_set_r;
            sllt_pkg::IDX_CUR_FF: rd_mux = cur_ff_r;
            sllt_pkg::IDX_SPD_SET: rd_mux = spd_set_r;
            sllt_pkg::IDX_SPD_FF: rd_mux = spd_ff_r;
            sllt_pkg::IDX_POS_SET: rd_mux = pos_set_r;
            sllt_pkg::IDX_MEAS_CUR: rd_mux = measured_currents_in;
            sllt_pkg::IDX_MEAS_SPD: rd_mux = measured_speed_in;
            sllt_pkg::IDX_MEAS_POS: rd_mux = meas_pos_r;
            default: rd_mux = sllt_pkg::REG_RST;
        endcase
        if (!addr_ok(s_axi_araddr)) begin
            rd_mux = sllt_pkg::REG_RST;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_r <= 1'b0;
            rdata_r <= sllt_pkg::REG_RST;
            rresp_r <= sllt_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= addr_ok(s_axi_araddr) ? sllt_pkg::RESP_OKAY : sllt_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ************************************************
    // mode decode
    // ************************************************
    // motion mode field
    assign loop_config.motion_mode = mode_r[sllt_pkg::MODE_MSB:sllt_pkg::MODE_LSB];
    assign loop_config.outer_downsample = mode_r[sllt_pkg::SMPL_MSB:sllt_pkg::SMPL_LSB];
    assign loop_config.pi_sequential = mode_r[sllt_pkg::PITYPE_BIT];

    logic torque_like, speed_like, pos_like;
    always_comb begin
        torque_like = 1'b0;
        speed_like = 1'b0;
        pos_like = 1'b0;
        case (sllt_pkg::sllt_mode_e'(loop_config.motion_mode))
            sllt_pkg::MM_TORQUE, sllt_pkg::MM_ANA_TORQUE,
            sllt_pkg::MM_PWM_TORQUE: torque_like = 1'b1;
            sllt_pkg::MM_VELOCITY, sllt_pkg::MM_ANA_VELOCITY,
            sllt_pkg::MM_PWM_VELOCITY: speed_like = 1'b1;
            sllt_pkg::MM_POSITION, sllt_pkg::MM_ANA_POSITION,
            sllt_pkg::MM_PWM_POSITION: pos_like = 1'b1;
            default: ;
        endcase
    end

    // ************************************************
    // setpoint limiters, outputs registered
    // ************************************************
    logic signed [32:0] cur_hi, spd_hi, spd_src;
    assign cur_hi = 33'(cur_lim_r[15:0]);
    assign spd_hi = 33'(spd_lim_r);
    assign spd_src = speed_like ? 33'(signed'(spd_set_r)) : 33'(position_loop_out);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            current_loop_target <= sllt_pkg::REG_RST;
            speed_loop_target <= sllt_pkg::REG_RST;
            position_loop_target <= sllt_pkg::REG_RST;
        end else begin
            current_loop_target.torque <= 16'(clamp32(33'(clamp32(
                33'(signed'(cur_set_r[31:16])), -cur_hi, cur_hi)) +
                33'(signed'(cur_ff_r[31:16])), -33'sd32768, 33'sd32767));
            current_loop_target.flux <= 16'(clamp32(33'(clamp32(
                33'(signed'(cur_set_r[15:0])), -cur_hi, cur_hi)) +
                33'(signed'(cur_ff_r[15:0])), -33'sd32768, 33'sd32767));
            speed_loop_target <= clamp32(33'(clamp32(spd_src, -spd_hi, spd_hi)) +
                ((speed_like || pos_like) ? 33'(signed'(spd_ff_r)) : 33'sd0),
                -33'sd2147483648, 33'sd2147483647);
            position_loop_target <= clamp32(33'(signed'(pos_set_r)),
                33'(signed'(pos_low_r)), 33'(signed'(pos_high_r)));
        end
    end

    // ************************************************
    // circular voltage limiter
    // ************************************************
    // the q bound is sqrt(lim^2 - d^2), found bit by bit over sixteen cycles,
    // so the output vector updates every eighteen cycles rather than each one
    logic [15:0] vlim_abs;
    logic [14:0] vlim;
    logic signed [15:0] d_hold_r, q_hold_r;
    logic [31:0] sq_op_r, sq_res_r, sq_bit_r;
    logic sq_busy_r;
    logic signed [16:0] d_cl;

    assign vlim_abs = volt_lim_r[15] ? 16'(-signed'(volt_lim_r[15:0])) : volt_lim_r[15:0];
    assign vlim = vlim_abs[15] ? sllt_pkg::VLIM_MAX : vlim_abs[14:0];
    assign d_cl = 17'(clamp32(33'(volt_d_in), -33'(vlim), 33'(vlim)));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sq_busy_r <= 1'b0;
            sq_op_r <= sllt_pkg::REG_RST;
            sq_res_r <= sllt_pkg::REG_RST;
            sq_bit_r <= sllt_pkg::REG_RST;
            d_hold_r <= 16'sh0000;
            q_hold_r <= 16'sh0000;
            volt_d_out <= 16'sh0000;
            volt_q_out <= 16'sh0000;
        end else if (!sq_busy_r) begin
            sq_busy_r <= 1'b1;
            d_hold_r <= d_cl[15:0];
            q_hold_r <= volt_q_in;
            sq_op_r <= 32'(32'(vlim) * 32'(vlim)) - 32'(d_cl * d_cl);
            sq_res_r <= sllt_pkg::REG_RST;
            sq_bit_r <= sllt_pkg::SQRT_BIT0;
        end else if (sq_bit_r != sllt_pkg::REG_RST) begin
            if (sq_op_r >= sq_res_r + sq_bit_r) begin
                sq_op_r <= sq_op_r - (sq_res_r + sq_bit_r);
                sq_res_r <= (sq_res_r >> 1) + sq_bit_r;
            end else begin
                sq_res_r <= sq_res_r >> 1;
            end
            sq_bit_r <= sq_bit_r >> 2;
        end else begin
            sq_busy_r <= 1'b0;
            volt_d_out <= d_hold_r;
            volt_q_out <= 16'(clamp32(33'(q_hold_r), -33'(sq_res_r[15:0]),
                                      33'(sq_res_r[15:0])));
        end
    end

endmodule

// ==== logic/sllt_pkg.sv ====
// package for the servo loop limit and target register bank
// assumes a 32-bit axi4-lite master and one 250 MHz clock
package sllt_pkg;

    // ************************************************
    // register indices, byte address is index times four
    // ************************************************
    localparam logic [7:0] IDX_VOLT_LIM = 8'h5d;
    localparam logic [7:0] IDX_CUR_LIM = 8'h5e;
    localparam logic [7:0] IDX_SPD_LIM = 8'h60;
    localparam logic [7:0] IDX_POS_LOW = 8'h61;
    localparam logic [7:0] IDX_POS_HIGH = 8'h62;
    localparam logic [7:0] IDX_MODE = 8'h63;
    localparam logic [7:0] IDX_CUR_SET = 8'h64;
    localparam logic [7:0] IDX_CUR_FF = 8'h65;
    localparam logic [7:0] IDX_SPD_SET = 8'h66;
    localparam logic [7:0] IDX_SPD_FF = 8'h67;
    localparam logic [7:0] IDX_POS_SET = 8'h68;
    localparam logic [7:0] IDX_MEAS_CUR = 8'h69;
    localparam logic [7:0] IDX_MEAS_SPD = 8'h6a;
    localparam logic [7:0] IDX_MEAS_POS = 8'h6b;
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 9;

    // ************************************************
    // field layout and reset values
    // ************************************************
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 7;
    localparam int SMPL_LSB = 24;
    localparam int SMPL_MSB = 30;
    localparam int PITYPE_BIT = 31;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [14:0] VLIM_MAX = 15'h7fff;
    localparam logic [31:0] SQRT_BIT0 = 32'h4000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************
    // motion modes
    // ************************************************
    typedef enum logic [7:0] {
        MM_STOPPED = 8'h00, MM_TORQUE = 8'h01, MM_VELOCITY = 8'h02, MM_POSITION = 8'h03,
        MM_PRBS_FLUX = 8'h04, MM_PRBS_TORQUE = 8'h05, MM_PRBS_VELOCITY = 8'h06,
        MM_PRBS_POSITION = 8'h07, MM_EXT_VOLTAGE = 8'h08, MM_RESERVED = 8'h09,
        MM_ANA_TORQUE = 8'h0a, MM_ANA_VELOCITY = 8'h0b, MM_ANA_POSITION = 8'h0c,
        MM_PWM_TORQUE = 8'h0d, MM_PWM_VELOCITY = 8'h0e, MM_PWM_POSITION = 8'h0f
    } sllt_mode_e;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        logic signed [15:0] torque;
        logic signed [15:0] flux;
    } sllt_dq_s;

    typedef struct packed {
        logic pi_sequential;
        logic [6:0] outer_downsample;
        logic [7:0] motion_mode;
    } sllt_cfg_s;
endpackage

// ==== bench/sllt_regs_properties.sv ====
// concurrent checks on the ports of the servo loop register bank
// assumes one clock, active low async reset, full-word writes from the master
`timescale 1ns/1ns
module sllt_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // cascade side
    input wire sllt_pkg::sllt_dq_s measured_currents_in,
    input wire logic selected_angle_valid,
    input wire sllt_pkg::sllt_cfg_s loop_config,
    input wire logic signed [31:0] measured_position
);
    // ************************************************
    // last accepted write, kept until its response
    // ************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    logic [31:0] aa_r;
    logic [35:0] wd_r;
    logic mode_w;
    logic pos_w;
    // address and data may be taken on different edges, so each is held alone
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aa_r <= '0;
            wd_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aa_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_r <= {s_axi_wstrb, s_axi_wdata};
        end
    end
    assign mode_w = aa_r == {22'h0, sllt_pkg::IDX_MODE, 2'h0} && wd_r[35:32] == 4'hf;
    assign pos_w = aa_r == {22'h0, sllt_pkg::IDX_MEAS_POS, 2'h0} && wd_r[35:32] == 4'hf;
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response not held");
    property p_ar_refused;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refused: assert property (p_ar_refused) else $error("read address open too early");
    property p_mode_field;
        $rose(s_axi_bvalid) && mode_w |-> loop_config.motion_mode == wd_r[7:0];
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("motion mode wrong");
    property p_downsample;
        $rose(s_axi_bvalid) && mode_w |-> loop_config.outer_downsample == wd_r[30:24];
    endproperty
    a_downsample: assert property (p_downsample) else $error("downsample wrong");
    property p_pi_type;
        $rose(s_axi_bvalid) && mode_w |-> loop_config.pi_sequential == wd_r[31];
    endproperty
    a_pi_type: assert property (p_pi_type) else $error("pi structure wrong");
    property p_cur_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {22'h0, sllt_pkg::IDX_MEAS_CUR, 2'h0}
            |=> s_axi_rdata == $past(measured_currents_in);
    endproperty
    a_cur_read: assert property (p_cur_read) else $error("measured currents misread");
    property p_pos_write;
        $rose(s_axi_bvalid) && pos_w |-> measured_position == wd_r[31:0];
    endproperty
    a_pos_write: assert property (p_pos_write) else $error("position write lost");
    property p_pos_still;
        (!selected_angle_valid && !s_axi_awvalid && !s_axi_wvalid) [*3]
            |=> $stable(measured_position);
    endproperty
    a_pos_still: assert property (p_pos_still) else $error("position moved unasked");
endmodule
bind sllt_regs sllt_properties u_props (.*);

// ==== bench/test_servo_loop_limit_target_regs.sv ====
// self-checking bench for the servo loop register bank
// assumes the bank answers on axi4-lite and the checker is bound beside it
`timescale 1ns/1ns
module test_servo_loop_limit_target_regs;
    typedef struct packed {logic [7:0] i; logic [31:0] w; logic [31:0] r;} sllt_row_s;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, selected_angle_valid = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, br, rr, er;
    sllt_pkg::sllt_dq_s measured_currents_in = 32'h1111_2222;
    sllt_pkg::sllt_dq_s current_loop_target;
    sllt_pkg::sllt_cfg_s loop_config;
    logic signed [31:0] measured_speed_in = 32'h3333, position_loop_out = '0, rv;
    logic signed [31:0] speed_loop_target, position_loop_target, measured_position;
    logic signed [15:0] selected_angle = '0, volt_d_in = '0, volt_q_in = '0;
    logic signed [15:0] volt_d_out, volt_q_out;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    sllt_row_s rows[14];

    sllt_regs u_dut (.*);

    always #2 ref_clk = ~ref_clk;
    // a hung handshake ends here instead of running forever
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ************************************************
    // bus and check tasks
    // ************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    // bready comes late on purpose so the response has to stand
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= {22'h0, i, 2'h0};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h1;
        @(posedge ref_clk);
        br = s_axi_bresp;
        s_axi_bready <= 1'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] i);
        @(posedge ref_clk);
        s_axi_araddr <= {22'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h1;
        @(posedge ref_clk);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic pulse(input logic [15:0] a);
        @(posedge ref_clk);
        selected_angle <= a;
        selected_angle_valid <= 1'h1;
        @(posedge ref_clk);
        selected_angle_valid <= 1'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic do_reset;
        nrst <= 1'h0;
        repeat (10) @(posedge ref_clk);
        chk("rst cfg", 32'h0, loop_config);
        chk("rst pos", 32'h0, measured_position);
        nrst <= 1'h1;
        rd(sllt_pkg::IDX_MODE);
        chk("rst mode", sllt_pkg::REG_RST, rv);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        // read-only rows expect the live input, the unmapped row reads zero
        rows = '{'{8'h5e, 32'h1234, 32'h1234}, '{8'h60, 32'h1_0000, 32'h1_0000},
            '{8'h61, 32'hffff_f000, 32'hffff_f000}, '{8'h62, 32'h1000, 32'h1000},
            '{8'h64, 32'h7000_9000, 32'h7000_9000}, '{8'h65, 32'h10_0020, 32'h10_0020},
            '{8'h66, 32'h8000, 32'h8000}, '{8'h67, 32'h10, 32'h10}, '{8'h68, 32'h2000, 32'h2000},
            '{8'h69, 32'h5555_aaaa, 32'h1111_2222}, '{8'h6a, 32'h1, 32'h3333},
            '{8'h5f, 32'hdead_beef, 32'h0}, '{8'h5d, 32'hff9c, 32'hff9c},
            '{8'h63, 32'hc500_0002, 32'hc500_0002}};
        do_reset();
        foreach (rows[k]) begin
            wr(rows[k].i, rows[k].w);
            rd(rows[k].i);
            er = rows[k].i == 8'h5f ? sllt_pkg::RESP_SLVERR : sllt_pkg::RESP_OKAY;
            chk("bresp", er, br);
            chk("rresp", er, rr);
            chk("rdata", rows[k].r, rv);
        end
        chk("cfg", 32'hc502, loop_config);
        for (int m = 0; m < 16; m++) begin
            wr(sllt_pkg::IDX_MODE, m);
            chk("mode", m, loop_config);
        end
        wr(sllt_pkg::IDX_MODE, 32'h2);
        chk("speed", 32'h8010, speed_loop_target);
        wr(sllt_pkg::IDX_SPD_SET, 32'hfffe_0000);
        chk("speed", 32'hffff_0010, speed_loop_target);
        position_loop_out <= 32'h64;
        wr(sllt_pkg::IDX_MODE, 32'h3);
        chk("speed", 32'h74, speed_loop_target);
        chk("pos", 32'h1000, position_loop_target);
        wr(sllt_pkg::IDX_POS_SET, 32'hffff_e000);
        chk("pos", 32'hffff_f000, position_loop_target);
        wr(sllt_pkg::IDX_POS_SET, 32'h800);
        chk("pos", 32'h800, position_loop_target);
        wr(sllt_pkg::IDX_MODE, 32'h1);
        chk("cur", 32'h1244_edec, current_loop_target);
        wr(sllt_pkg::IDX_CUR_SET, 32'h0100_ff00);
        chk("cur", 32'h0110_ff20, current_loop_target);
        {volt_d_in, volt_q_in} <= {16'h3c, 16'h64};
        repeat (40) @(posedge ref_clk);
        chk("volt", 32'h3c_0050, {volt_d_out, volt_q_out});
        pulse(16'h7000);
        wr(sllt_pkg::IDX_MEAS_POS, 32'h1_0000);
        rd(sllt_pkg::IDX_POS_SET);
        chk("pset", 32'h1_0000, rv);
        pulse(16'h9000);
        pulse(16'hf000);
        pulse(16'h1000);
        chk("mpos", 32'h1_a000, measured_position);
        rd(sllt_pkg::IDX_MEAS_POS);
        chk("mpos", 32'h1_a000, rv);
        do_reset();
        end_of_test();
    end
endmodule
